// [dv/tb_tr_switch_sync_debounce.sv]
`timescale 1ns/1ns
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
    $display("BAD %s exp %0b got %0b", n, e, g); end end
module tb_tr_switch_sync_debounce;
    logic core_clk = 1'h0;
    logic rst_n = 1'h0;
    logic mt = 1'h0;
    logic mr = 1'h0;
    logic fire = 1'h0;
    logic [3:0] hi_len = 4'h4;
    logic tr_in, tr_out, tr_out_n, manual_warn, warn_flag;
    int bad_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    // reference model state
    logic e_man = 1'h0;
    logic e_tx = 1'h0;
    logic e_low = 1'h0;
    logic s_man, s_tx;
    tsd_top #(.DEB_CYCLES(8)) dut_u (.core_clk(core_clk), .rst_n(rst_n),
        .manual_transmit(mt), .manual_receive(mr), .tr_in(tr_in), .tr_out(tr_out),
        .tr_out_n(tr_out_n), .manual_warn(manual_warn));
    tsd_tr_src src_u (.core_clk(core_clk), .rst_n(rst_n), .fire(fire), .hi_len(hi_len),
        .tr_in(tr_in), .manual_warn(manual_warn), .warn_flag(warn_flag));
    always #2 core_clk = ~core_clk;
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            bad_count++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // bounce shorter than the filter, then settle on the new position
    task automatic sel(input logic t, input logic r);
        logic pt, pr;
        pt = mt;
        pr = mr;
        @(posedge core_clk);
        repeat (3)
        begin
            {mt, mr} <= {t, r};
            repeat ($urandom % 6 + 1) @(posedge core_clk);
            {mt, mr} <= {pt, pr};
            @(posedge core_clk);
        end
        {mt, mr} <= {t, r};
        repeat (14) @(posedge core_clk);
        #1;
        if (t ^ r)
        begin
            e_man = 1'h1;
            e_tx = t;
        end
        else if (!t)
            e_man = 1'h0;
        `CHK("warn", e_man, manual_warn)
        `CHK("hold", e_low, tr_out)
        `CHK("hold_n", ~e_low, tr_out_n)
    endtask
    // one pulse of w cycles; model samples latches at its rising edge
    task automatic pulse(input logic [3:0] w);
        @(posedge core_clk);
        hi_len <= w;
        fire <= 1'h1;
        @(posedge core_clk);
        fire <= 1'h0;
        s_man = e_man;
        s_tx = e_tx;
        repeat (3) @(posedge core_clk);
        #1;
        `CHK("high", s_man ? s_tx : 1'h1, tr_out)
        `CHK("inv", ~(s_man ? s_tx : 1'h1), tr_out_n)
        repeat (16) @(posedge core_clk);
        #1;
        e_low = s_man ? s_tx : 1'h0;
        `CHK("low", e_low, tr_out)
    endtask
    initial
    begin
        void'($urandom(32'h2e9a6c36));
        repeat (8) @(posedge core_clk);
        rst_n <= 1'h1;
        pulse(4'h1);
        pulse(4'(4 + $urandom % 8));
        sel(1'h1, 1'h0);
        sel(1'h1, 1'h1);
        pulse(4'(4 + $urandom % 8));
        pulse(4'(4 + $urandom % 8));
        sel(1'h0, 1'h1);
        pulse(4'(4 + $urandom % 8));
        sel(1'h0, 1'h0);
        pulse(4'(4 + $urandom % 8));
        `CHK("sticky", 1'h1, warn_flag)
        finish_test();
    end
endmodule

// [dv/tsd_tr_src.sv]
`timescale 1ns/1ns
// upstream pulse-train driver plus the monitor's sticky warning flag
module tsd_tr_src (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // one pulse per fire, hi_len cycles high
    input wire logic fire,
    input wire logic [3:0] hi_len,
    output logic tr_in,
    // monitor side
    input wire logic manual_warn,
    output logic warn_flag
);
    logic [3:0] cnt;
    // pulse width counter; line idles low between pulses
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            tr_in <= 1'h0;
            cnt <= 4'h0;
            warn_flag <= 1'h0;
        end
        else
        begin
            if (fire)
            begin
                tr_in <= 1'h1;
                cnt <= hi_len;
            end
            else if (cnt > 4'h1)
                cnt <= cnt - 4'h1;
            else
                tr_in <= 1'h0;
            if (manual_warn)
                warn_flag <= 1'h1;
        end
    end
endmodule

// [src/tsd_pkg.sv]
package tsd_pkg;
    // clock rate and selector settle time
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned DEB_TIME_US = 1000;
    localparam int unsigned DEB_CYCLES_DEF = DEB_TIME_US * CLK_MHZ;
    localparam int unsigned DEB_CNT_W = 18;

    // decoded selector positions, one-hot bit indices
    localparam int unsigned POS_TX = 0;
    localparam int unsigned POS_RX = 1;
    localparam int unsigned POS_AUTO = 2;
    localparam logic [2:0] POS_NONE = 3'h0;

    // reset values
    localparam logic TR_OUT_RST = 1'h0;
    localparam logic MANUAL_RST = 1'h0;
    localparam logic TXRX_RST = 1'h0;

    typedef struct packed {
        logic [2:0] pos_prev;
        logic [DEB_CNT_W-1:0] stable_cnt;
        logic txrx;
        logic manual;
        logic tr_prev;
        logic sel_manual;
        logic sel_tx;
        logic tr_out;
        logic tr_out_n;
        logic warn;
    } tsd_state_t;
endpackage

// [src/tsd_sync2.sv]
`timescale 1ns/1ns
// two-stage synchroniser for asynchronous pins
module tsd_sync2 #(
    parameter int unsigned WIDTH = 1
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] held;
    } tsd_sync_t;

    tsd_sync_t st;
    tsd_sync_t next_st;

    // first stage feeds only the second
    always_comb
    begin
        next_st.meta = async_in;
        next_st.held = st.meta;
    end

    // stage register; reset clears both stages
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign sync_out = st.held;
endmodule

// [src/tsd_top.sv]
// Summary of operation
// - output changes only with incoming pulse train
// - no short pulses when selector moves
// - selector bounce filtered to one clean change
// - warning high in either manual position
// - selector contacts decoded to exclusive positions
// - two latches: transmit/receive and manual/auto
// - auto passes pulse train, manual forces level
// - manual choice registered on pulse train edge
// - complemented copy of output provided
`timescale 1ns/1ns
module tsd_top
    import tsd_pkg::*;
#(
    parameter int unsigned DEB_CYCLES = DEB_CYCLES_DEF
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // front-panel mode_selector contacts, high when closed
    input wire logic manual_transmit,
    input wire logic manual_receive,
    // incoming transmit/receive pulse train, high means transmit
    input wire logic tr_in,
    // outputs to circulator driver and other subassemblies
    output logic tr_out,
    output logic tr_out_n,
    // manual-override warning, level
    output logic manual_warn
);
    // counter end points; the count parks at full, so a settled position
    // fires the latches once however long the selector rests there
    localparam logic [DEB_CNT_W-1:0] DEB_LAST = DEB_CNT_W'(DEB_CYCLES - 1);
    localparam logic [DEB_CNT_W-1:0] DEB_FULL = DEB_CNT_W'(DEB_CYCLES);

    // reset state: auto mode, receive level, output low
    localparam tsd_state_t ST_RST = '{
        pos_prev: POS_NONE,
        stable_cnt: '0,
        txrx: TXRX_RST,
        manual: MANUAL_RST,
        tr_prev: 1'h0,
        sel_manual: MANUAL_RST,
        sel_tx: TXRX_RST,
        tr_out: TR_OUT_RST,
        tr_out_n: ~TR_OUT_RST,
        warn: MANUAL_RST
    };

    tsd_state_t st;
    tsd_state_t next_st;
    logic [2:0] pins_s;
    logic tx_s;
    logic rx_s;
    logic tr_s;
    logic [2:0] pos;
    logic tr_rise;

    // all three pins are asynchronous to core_clk; tr_in shares the two
    // stages with the contacts, so pulse train and contacts reach the logic after the same two-cycle delay
    tsd_sync2 #(
        .WIDTH(3)
    ) u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .async_in({tr_in, manual_receive, manual_transmit}),
        .sync_out(pins_s)
    );

    assign tx_s = pins_s[0];
    assign rx_s = pins_s[1];
    assign tr_s = pins_s[2];
    // tr_prev resets low like the idle line, so no false edge follows reset
    assign tr_rise = tr_s & ~st.tr_prev;

    // break-before-make decode; both contacts closed decodes to nothing
    always_comb
    begin
        pos = POS_NONE;
        pos[POS_TX] = tx_s & ~rx_s;
        pos[POS_RX] = rx_s & ~tx_s;
        pos[POS_AUTO] = ~tx_s & ~rx_s;
    end

    // next-state logic for the whole block
    always_comb
    begin
        next_st = st;
        next_st.pos_prev = pos;
        next_st.tr_prev = tr_s;
        // a position must hold steady before the latches see it, so bounce
        // and the overlap during travel never toggle them twice
        if ((pos != st.pos_prev) || (pos == POS_NONE))
        begin
            next_st.stable_cnt = '0;
        end
        else if (st.stable_cnt != DEB_FULL)
        begin
            next_st.stable_cnt = st.stable_cnt + DEB_CNT_W'(1);
        end
        if ((pos == st.pos_prev) && (pos != POS_NONE) && (st.stable_cnt == DEB_LAST))
        begin
            // transmit/receive latch, untouched in auto
            if (pos[POS_TX])
            begin
                next_st.txrx = 1'b1;
            end
            else if (pos[POS_RX])
            begin
                next_st.txrx = 1'b0;
            end
            // manual/auto latch
            next_st.manual = pos[POS_TX] | pos[POS_RX];
        end
        // choice moves only on a pulse train edge; the edge is when the
        // input rises, so no switch-over can clip a pulse
        if (tr_rise)
        begin
            next_st.sel_manual = st.manual;
            next_st.sel_tx = st.txrx;
        end
        // selector between pulse train and forced level
        next_st.tr_out = next_st.sel_manual ? next_st.sel_tx : tr_s;
        next_st.tr_out_n = ~next_st.tr_out;
        // warning reflects the resting, debounced position; taking it from the
        // raw contacts would let bounce flicker the monitor's sticky flag
        next_st.warn = next_st.manual;
    end

    // state register
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            st <= ST_RST;
        end
        else
        begin
            st <= next_st;
        end
    end

    // outputs come straight from the state register
    // limitation: with no pulses arriving, a manual choice never reaches tr_out
    assign tr_out = st.tr_out;
    assign tr_out_n = st.tr_out_n;
    assign manual_warn = st.warn;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    // selector choice only moves on a rising pulse edge
    sel_sync_edge_a: assert property ($changed(st.sel_manual) |-> $past(tr_rise))
        else $error("mode choice changed away from a pulse edge");

    // steady manual state holds the output steady
    manual_hold_a: assert property (
        (st.sel_manual && $stable(st.sel_manual) && $stable(st.sel_tx)) |-> $stable(tr_out))
        else $error("output moved while manual state held");

    // latches change only after a full settle count
    debounce_wait_a: assert property (
        ($changed(st.manual) || $changed(st.txrx)) |-> ($past(st.stable_cnt) == DEB_LAST))
        else $error("latch changed before selector settled");

    // warning changes in the same cycle as the manual latch; checked the cycle after the change
    warn_follow_a: assert property ($changed(st.manual) |=> (manual_warn == $past(st.manual)))
        else $error("warning not tracking manual latch");

    // decoded positions never overlap
    pos_onehot_a: assert property ($onehot0(pos))
        else $error("decoded positions overlap");

    // auto position leaves transmit/receive latch alone
    txrx_hold_a: assert property ((pos == (3'h1 << POS_AUTO)) |=> $stable(st.txrx))
        else $error("transmit/receive latch moved in auto");

    // auto passes pulse train, manual forces level
    route_auto_a: assert property (!st.sel_manual |-> (tr_out == $past(tr_s)))
        else $error("auto mode not passing pulse train");
    route_manual_a: assert property (st.sel_manual |-> (tr_out == st.sel_tx))
        else $error("manual mode not forcing latched level");

    // complement tracks output
    out_comp_a: assert property (tr_out_n == ~tr_out)
        else $error("inverted output mismatch");

    // rising edge samples the debounced choice
    edge_sample_a: assert property (tr_rise |=> (st.sel_manual == $past(st.manual)))
        else $error("choice not sampled on rising edge");

    // output moves only with the pulse train
    out_sync_a: assert property (
        $changed(tr_out) |-> ($past(tr_rise) || ($past(tr_s) != $past(tr_s, 2))))
        else $error("output moved away from the pulse train");

    // a one-cycle output pulse needs a one-cycle input pulse
    pulse_width_a: assert property (
        ($rose(tr_out) ##1 $fell(tr_out)) |-> ($past(tr_s, 2) && !$past(tr_s)))
        else $error("output pulse shorter than the pulse train");

    // any movement of the decoded position restarts the settle count
    settle_restart_a: assert property ((pos != st.pos_prev) |=> (st.stable_cnt == '0))
        else $error("settle count not restarted on movement");

    // the manual latch cannot move twice inside one settle time of eight or more
    debounce_gap_a: assert property ($changed(st.manual) |=> $stable(st.manual) [*7])
        else $error("manual latch toggled twice");

    // a settled manual position shows on the warning
    warn_pos_a: assert property (
        (st.stable_cnt == DEB_FULL)
        |-> (manual_warn == (st.pos_prev[POS_TX] | st.pos_prev[POS_RX])))
        else $error("warning disagrees with settled position");

    // a settled manual position sets the transmit/receive latch to match
    txrx_pos_a: assert property (
        (st.stable_cnt == DEB_FULL && !st.pos_prev[POS_AUTO])
        |-> (st.txrx == st.pos_prev[POS_TX]))
        else $error("transmit/receive latch disagrees with settled position");

    // both contacts closed decodes to no position
    overlap_none_a: assert property ((tx_s && rx_s) |-> (pos == POS_NONE))
        else $error("overlapping contacts decoded to a position");
endmodule
